// ===== logic/sigma_delta_output_filter.sv
// Purpose: Decimating six-pole low-pass filter and 16-bit result register of a sigma-delta converter.
// Assumes: clk is the master clock; modBit is the modulator bitstream, synchronous to clk.
// Notes:   All rates are fixed cycle ratios, so the response scales with the clock frequency.

// Summary of operation
// - Filter corner sits at master clock divided by 409600.
// - At 4.096 MHz the corner is 10 Hz and words come at 4 kHz.
// - Six-pole Gaussian-shaped low-pass response.
// - Step response settles without overshoot; worst case 125 ms at 4.096 MHz.
// - Conversion runs continuously; no start command exists.
// - 16-bit result register refreshed at 4 kHz, readable at any time.
// - Every rate derives from the master clock by fixed ratios.
// - Polarity select low gives unipolar span zero to reference.
// - Polarity select high gives bipolar span minus to plus reference.
// - Straight binary in unipolar mode, offset binary in bipolar mode.
// - Midscale transition half an LSB above the zero point; codes span all zeros to all ones.
// - One LSB is the input span divided by 65536.
// - Input sampled every 256 cycles with 62 cycles of settling first.
// - Sampling at 16 kHz with the nominal master clock.
module sigma_delta_output_filter #(
  parameter int SETTLE_COUNT = sd_filter_pkg::SETTLE_CYCLES
) (
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic                              modBit,
  input  wire logic                              polarity_select,
  input  wire logic                              restartSettle,
  input  wire logic                              holdResult,
  output logic                                   sampleStrobe,
  output logic [sd_filter_pkg::CODE_W-1:0]       resultWord,
  output logic                                   wordStrobe,
  output logic                                   overRange,
  output logic                                   settled
);

  localparam int ACC_W  = sd_filter_pkg::ACC_W;
  localparam int HALF_W = sd_filter_pkg::HALF_W;
  localparam int CODE_W = sd_filter_pkg::CODE_W;

  // Signed full-scale values of the modulator bit: +1.0 for a one, -1.0 for a zero.
  localparam logic signed [ACC_W-1:0] PLUS_ONE  = ACC_W'(1 <<< sd_filter_pkg::FRAC_BITS);
  localparam logic signed [ACC_W-1:0] MINUS_ONE = -PLUS_ONE;

  // Turn a filter value into a code counted in half LSBs, before the half-LSB shift.
  // Bipolar: span of two units maps to 65536 LSB, with zero at midscale.
  // Unipolar: one unit maps to 65536 LSB, with zero at code zero.
  function automatic logic signed [HALF_W-1:0] to_half_lsb(
    input logic signed [ACC_W-1:0] value,
    input logic                    bipolar
  );
    logic signed [ACC_W-1:0] scaled;
    scaled = bipolar ? (value >>> 6) : (value >>> 5);
    to_half_lsb = bipolar ? (HALF_W'(scaled) + $signed(sd_filter_pkg::BIPOLAR_OFFSET_HALF))
                          : HALF_W'(scaled);
  endfunction

  // Span tests, shared by the clamp and by the out-of-range flag so the two can never disagree.
  function automatic logic below_span(input logic signed [HALF_W-1:0] lsb);
    below_span = (lsb < 0);
  endfunction

  function automatic logic above_span(input logic signed [HALF_W-1:0] lsb);
    above_span = (lsb > $signed({4'h0, sd_filter_pkg::CODE_MAX}));
  endfunction

  // Clamp a signed LSB count into the 16-bit code range.
  // Saturating rather than wrapping keeps an overdriven input from reading as the opposite limit.
  function automatic logic [CODE_W-1:0] clamp_code(input logic signed [HALF_W-1:0] lsb);
    if (below_span(lsb)) begin
      clamp_code = sd_filter_pkg::CODE_MIN;
    end else if (above_span(lsb)) begin
      clamp_code = sd_filter_pkg::CODE_MAX;
    end else begin
      clamp_code = lsb[CODE_W-1:0];
    end
  endfunction

  // Rate pulses. Sampling and word rates are plain cycle ratios of clk.
  logic sampleTick;
  logic wordTick;

  rate_divider #(
    .WIDTH  (sd_filter_pkg::SAMPLE_CNT_W),
    .PERIOD (sd_filter_pkg::SAMPLE_PERIOD)
  ) sampleDivider (
    .clk  (clk),
    .rst  (rst),
    .tick (sampleTick)
  );

  rate_divider #(
    .WIDTH  (sd_filter_pkg::WORD_CNT_W),
    .PERIOD (sd_filter_pkg::WORD_PERIOD)
  ) wordDivider (
    .clk  (clk),
    .rst  (rst),
    .tick (wordTick)
  );

  // Sampling phase: wait for the sample pulse, let the input settle, then step the filter.
  // Nothing starts a conversion; the sequence runs from reset onward forever.
  sd_filter_pkg::phase_type phase;
  sd_filter_pkg::phase_type next_phase;
  logic [5:0]               settleCount;
  wire                      settleDone = (settleCount == 6'(sd_filter_pkg::INPUT_SETTLE_CYCLES - 1));

  always_comb begin
    next_phase = phase;
    unique case (phase)
      sd_filter_pkg::WAIT_SAMPLE: begin
        if (sampleTick) next_phase = sd_filter_pkg::INPUT_SETTLE;
      end
      sd_filter_pkg::INPUT_SETTLE: begin
        if (settleDone) next_phase = sd_filter_pkg::FILTER_STEP;
      end
      sd_filter_pkg::FILTER_STEP: begin
        next_phase = sd_filter_pkg::WAIT_SAMPLE;
      end
      default: begin
        next_phase = sd_filter_pkg::WAIT_SAMPLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase <= sd_filter_pkg::WAIT_SAMPLE;
    end else begin
      phase <= next_phase;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || phase != sd_filter_pkg::INPUT_SETTLE) begin
      settleCount <= '0;
    end else begin
      settleCount <= settleCount + 1'b1;
    end
  end

  // The modulator is told when the sample is taken so it can hold the input.
  always_ff @(posedge clk) begin
    if (rst) begin
      sampleStrobe <= 1'b0;
    end else begin
      sampleStrobe <= sampleTick;
    end
  end

  // The bit is taken only after the settling window has passed.
  wire                      filterStep = (phase == sd_filter_pkg::FILTER_STEP);
  wire signed [ACC_W-1:0]   inputValue = modBit ? PLUS_ONE : MINUS_ONE;

  // Cascade of six identical real poles. Identical real poles give a Gaussian-like
  // response with a monotonic step response, so there is never any overshoot.
  // The shift sets each pole; with six in cascade the overall corner lands near
  // the sample rate divided by 1600, that is the master clock divided by 409600.
  // A binary shift trades a little corner accuracy for having no multiplier.
  logic signed [ACC_W-1:0] pole [sd_filter_pkg::POLE_COUNT];
  wire  signed [ACC_W-1:0] poleIn [sd_filter_pkg::POLE_COUNT];

  genvar k;
  generate
    for (k = 0; k < sd_filter_pkg::POLE_COUNT; k++) begin : poles
      if (k == 0) begin : first
        assign poleIn[k] = inputValue;
      end else begin : later
        assign poleIn[k] = pole[k-1];
      end

      wire signed [ACC_W-1:0] poleDelta = (poleIn[k] - pole[k]) >>> sd_filter_pkg::POLE_SHIFT;

      always_ff @(posedge clk) begin
        if (rst) begin
          pole[k] <= '0;
        end else if (filterStep) begin
          pole[k] <= pole[k] + poleDelta;
        end
      end
    end
  endgenerate

  wire signed [ACC_W-1:0] filterOut = pole[sd_filter_pkg::POLE_COUNT-1];

  // Output coding. The half-LSB step down places the midscale transition half an LSB
  // above the zero point, and the final shift gives whole LSBs of span/65536.
  wire signed [HALF_W-1:0] halfLsb      = to_half_lsb(filterOut, polarity_select);
  wire signed [HALF_W-1:0] shiftedHalf  = halfLsb - HALF_W'(1);
  wire signed [HALF_W-1:0] wholeLsb     = shiftedHalf >>> 1;
  wire        [CODE_W-1:0] codedWord    = clamp_code(wholeLsb);
  wire                     outsideSpan  = below_span(wholeLsb) || above_span(wholeLsb);

  // A word is captured at each word pulse and offered to the buffer. If the buffer is
  // full the pending word is held and replaced by the newest one, so back-pressure
  // never stalls the filter itself, but a pending word that is replaced is lost.
  logic              pendingValid;
  logic [CODE_W:0]   pendingWord;
  wire               pushReady;
  wire [CODE_W:0]    fifoOut;
  wire               fifoValid;
  wire               popReady = !holdResult;

  always_ff @(posedge clk) begin
    if (rst) begin
      pendingValid <= 1'b0;
      pendingWord  <= '0;
    end else begin
      if (wordTick) begin
        pendingWord  <= {outsideSpan, codedWord};
        pendingValid <= 1'b1;
      end else if (pushReady) begin
        pendingValid <= 1'b0;
      end
    end
  end

  word_fifo #(
    .WIDTH (CODE_W + 1),
    .DEPTH (sd_filter_pkg::FIFO_DEPTH)
  ) resultBuffer (
    .clk      (clk),
    .rst      (rst),
    .inData   (pendingWord),
    .inValid  (pendingValid && !wordTick),
    .inReady  (pushReady),
    .outData  (fifoOut),
    .outValid (fifoValid),
    .outReady (popReady)
  );

  // The result register takes a whole word in one edge, so a read never sees a blend.
  // Holding the register lets a slow reader finish; words wait in the buffer meanwhile.
  wire loadResult = fifoValid && popReady;

  always_ff @(posedge clk) begin
    if (rst) begin
      resultWord <= sd_filter_pkg::CODE_RESET;
      overRange  <= 1'b0;
      wordStrobe <= 1'b0;
    end else begin
      wordStrobe <= loadResult;
      if (loadResult) begin
        resultWord <= fifoOut[CODE_W-1:0];
        overRange  <= fifoOut[CODE_W];
      end
    end
  end

  // Settling indicator: counts the worst-case settling time from reset or from a
  // channel change reported by the host, so the host knows when words become valid.
  // The timer does not watch the input itself, so a step the host does not report goes unflagged.
  localparam int SETTLE_CNT_W_FIX = sd_filter_pkg::SETTLE_CNT_W;
  logic [SETTLE_CNT_W_FIX-1:0] settleTimer;
  wire timerDone = (settleTimer == SETTLE_CNT_W_FIX'(SETTLE_COUNT - 1));

  always_ff @(posedge clk) begin
    if (rst || restartSettle) begin
      settleTimer <= '0;
      settled     <= 1'b0;
    end else if (!settled) begin
      settleTimer <= settleTimer + 1'b1;
      settled     <= timerDone;
    end
  end

endmodule // sigma_delta_output_filter

// ===== pkg/sd_filter_pkg.sv
// Purpose: Shared constants for the sigma-delta output filter.
// Assumes: clk is the master clock; every rate below is a fixed ratio of it.
// Notes:   Times are kept in their own units and turned into cycle counts here.
package sd_filter_pkg;

  // Nominal master clock; only the derived figures below depend on it.
  localparam int MASTER_CLOCK_HZ     = 4096000;
  localparam int CORNER_DIVIDE       = 409600;
  localparam int CORNER_MILLIHZ      = (MASTER_CLOCK_HZ / CORNER_DIVIDE) * 1000;

  // Modulator sampling and input settling, in master clock cycles.
  localparam int SAMPLE_PERIOD       = 256;
  localparam int INPUT_SETTLE_CYCLES = 62;
  localparam int SAMPLE_RATE_HZ      = MASTER_CLOCK_HZ / SAMPLE_PERIOD;

  // Output word rate: 4 kHz at the nominal clock.
  localparam int WORD_RATE_HZ        = 4000;
  localparam int WORD_PERIOD         = 1024;
  localparam int SAMPLES_PER_WORD    = WORD_PERIOD / SAMPLE_PERIOD;

  // Worst-case step settling time and its cycle count (rounded down is exact here).
  localparam int SETTLE_TIME_MS      = 125;
  localparam int SETTLE_CYCLES       = SETTLE_TIME_MS * (MASTER_CLOCK_HZ / 1000);

  // Counter widths.
  localparam int SAMPLE_CNT_W        = 8;
  localparam int WORD_CNT_W          = 10;
  localparam int SETTLE_CNT_W        = 20;

  // Filter arithmetic: signed fixed point, 1.0 equals 2**FRAC_BITS.
  localparam int FRAC_BITS           = 22;
  localparam int ACC_W               = 26;
  localparam int POLE_COUNT          = 6;
  localparam int POLE_SHIFT          = 6;

  // Output coding.
  localparam int CODE_W              = 16;
  localparam int HALF_W              = 20;
  localparam logic [CODE_W-1:0] CODE_MAX   = 16'hffff;
  localparam logic [CODE_W-1:0] CODE_MIN   = 16'h0000;
  localparam logic [CODE_W-1:0] CODE_RESET = 16'h8000;
  localparam logic [HALF_W-1:0] BIPOLAR_OFFSET_HALF = 20'h10000;

  // Buffer between filter and result register.
  localparam int FIFO_DEPTH          = 8;

  typedef enum logic [2:0] {
    WAIT_SAMPLE  = 3'b001,
    INPUT_SETTLE = 3'b010,
    FILTER_STEP  = 3'b100
  } phase_type;

endpackage

// ===== logic/word_fifo.sv
// Purpose: Small first-in first-out buffer with valid/ready on both sides.
// Assumes: Single clock, synchronous active-high reset.
// Notes:   Storage is a flip-flop array indexed by read and write pointers.
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] writePtr;
  logic [PTR_W-1:0] readPtr;
  logic [PTR_W:0]   fill;
  wire              doPush = inValid && inReady;
  wire              doPop  = outValid && outReady;

  assign inReady  = (fill != (PTR_W+1)'(DEPTH));
  assign outValid = (fill != '0);
  assign outData  = store[readPtr];

  always_ff @(posedge clk) begin
    if (doPush) begin
      store[writePtr] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      writePtr <= '0;
      readPtr  <= '0;
      fill     <= '0;
    end else begin
      if (doPush) writePtr <= writePtr + 1'b1;
      if (doPop) readPtr <= readPtr + 1'b1;
      fill <= fill + (PTR_W+1)'(doPush) - (PTR_W+1)'(doPop);
    end
  end

endmodule // word_fifo

// ===== logic/rate_divider.sv
// Purpose: Free-running divider giving one-cycle enable pulses at a fixed ratio.
// Assumes: Single clock, synchronous active-high reset.
// Notes:   The pulse is registered, so it comes in the first cycle of each period, with the count back at zero.
module rate_divider #(
  parameter int WIDTH  = 8,
  parameter int PERIOD = 256
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      tick
);

  logic [WIDTH-1:0] count;
  wire              atEnd = (count == WIDTH'(PERIOD - 1));

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      count <= atEnd ? '0 : count + 1'b1;
      tick  <= atEnd;
    end
  end

endmodule // rate_divider

// ===== sim/sd_filter_props.sv
// Purpose: Port-level timing checks for the filter top.
// Assumes: Single clock, synchronous active-high reset.
// Notes:   Long periods are counted in helper registers instead of long repetitions.
module sd_filter_props #(
  parameter int SETTLE_COUNT = 2000
) (
  input wire logic                              clk,
  input wire logic                              rst,
  input wire logic                              modBit,
  input wire logic                              polarity_select,
  input wire logic                              restartSettle,
  input wire logic                              holdResult,
  input wire logic                              sampleStrobe,
  input wire logic [sd_filter_pkg::CODE_W-1:0]  resultWord,
  input wire logic                              wordStrobe,
  input wire logic                              overRange,
  input wire logic                              settled
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic [7:0]  sCnt;
  logic [9:0]  wCnt;
  logic [11:0] holdAge;
  logic [2:0]  perWord;
  logic [20:0] stCnt;
  logic        sSeen;
  logic        wSeen;
  // Buffered words drain back to back after a stall, so cadence is only judged well after one.
  wire         steady = wSeen && (holdAge > 12'd2100);

  always_ff @(posedge clk) begin
    sCnt    <= (rst || sampleStrobe) ? '0 : sCnt + 1'b1;
    wCnt    <= (rst || wordStrobe) ? '0 : wCnt + 1'b1;
    perWord <= (rst || wordStrobe) ? {2'b00, sampleStrobe} : perWord + {2'b00, sampleStrobe};
    holdAge <= (rst || holdResult) ? '0 : holdAge + {11'h000, ~&holdAge};
    stCnt   <= (rst || restartSettle) ? '0 : stCnt + {20'h00000, ~&stCnt};
    sSeen   <= !rst && (sSeen || sampleStrobe);
    wSeen   <= !rst && (wSeen || wordStrobe);
  end

  sample_period_a: assert property (sampleStrobe && sSeen |-> sCnt == 8'hff)
    else $error("sample strobe spacing is not 256 cycles");
  word_period_a: assert property (wordStrobe && steady |-> wCnt == 10'h3ff)
    else $error("word strobe spacing is not 1024 cycles");
  word_samples_a: assert property (wordStrobe && steady |-> perWord == 3'h4)
    else $error("sample count per word is not four");
  whole_load_a: assert property (!$stable(resultWord) |-> wordStrobe)
    else $error("result word changed without a word strobe");
  hold_freeze_a: assert property (holdResult |=> !wordStrobe && $stable(resultWord))
    else $error("result word moved while held");
  clamp_code_a: assert property (overRange |-> resultWord inside {16'hffff, 16'h0000})
    else $error("clamped word is not at a span limit");
  settle_time_a: assert property ($rose(settled) |-> stCnt >= SETTLE_COUNT - 2 && stCnt <= SETTLE_COUNT + 2)
    else $error("settled flag rose at the wrong time");
  free_run_a: assert property ($fell(rst) |-> ##[1:300] sampleStrobe)
    else $error("sampling did not start by itself");

  cover property (wordStrobe && overRange);
  cover property ($rose(settled));
  cover property ($fell(holdResult) ##[1:4] wordStrobe);
endmodule // sd_filter_props

bind sigma_delta_output_filter sd_filter_props #(.SETTLE_COUNT(SETTLE_COUNT)) props_i (
  .clk(clk), .rst(rst), .modBit(modBit), .polarity_select(polarity_select), .restartSettle(restartSettle),
  .holdResult(holdResult), .sampleStrobe(sampleStrobe), .resultWord(resultWord), .wordStrobe(wordStrobe),
  .overRange(overRange), .settled(settled));

// ===== sim/host_reader.sv
// Purpose: Host model that stalls the result path and announces channel changes.
// Assumes: Same clock as the filter; requests come from the bench.
// Notes:   Words count as usable only while the filter reports it has settled.
module host_reader (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic holdReq,
  input  wire logic chanReq,
  input  wire logic wordStrobe,
  input  wire logic settled,
  output logic      holdResult,
  output logic      restartSettle,
  output int        acceptCount
);
  // Requests are taken at the edge, where the bench's last change has long settled, and driven
  // one step later; the word strobe is judged after the edge that launched it.
  // There is no start request to send; the host only stalls or restarts settling.
  initial begin
    logic h;
    logic c;
    holdResult = 1'b0;
    restartSettle = 1'b0;
    acceptCount = 0;
    forever begin
      @(posedge clk);
      h = holdReq;
      c = chanReq;
      #1;
      holdResult = h;
      restartSettle = c;
      if (wordStrobe === 1'b1 && settled === 1'b1 && rst === 1'b0) acceptCount++;
    end
  end
endmodule // host_reader

// ===== sim/tb_sigma_delta_output_filter.sv
// Purpose: Self-checking bench for the sigma-delta output filter.
// Assumes: 100 MHz clock; a short settling count keeps the run brief.
// Notes:   Rising words are judged by relation, since exact codes need far longer settling; clamped words are checked exactly.
module tb_sigma_delta_output_filter;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 2000;
  typedef struct {
    int          mode;
    logic [15:0] val;
  } note_type;
  logic        clk, rst, modBit, polarity_select, holdReq, chanReq;
  logic        holdResult, restartSettle, sampleStrobe, wordStrobe, overRange, settled;
  logic [15:0] resultWord, prevWord;
  int          err_count, n_compared, acceptCount;
  note_type    notes[$];

  sigma_delta_output_filter #(.SETTLE_COUNT(SC)) dut (
    .clk(clk), .rst(rst), .modBit(modBit), .polarity_select(polarity_select), .restartSettle(restartSettle),
    .holdResult(holdResult), .sampleStrobe(sampleStrobe), .resultWord(resultWord), .wordStrobe(wordStrobe),
    .overRange(overRange), .settled(settled));
  host_reader host (.clk(clk), .rst(rst), .holdReq(holdReq), .chanReq(chanReq), .wordStrobe(wordStrobe),
    .settled(settled), .holdResult(holdResult), .restartSettle(restartSettle), .acceptCount(acceptCount));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(string name, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic drain;
    int t;
    t = 0;
    while (notes.size() != 0 && t < 30000) begin
      @(posedge clk);
      t++;
    end
    if (notes.size() != 0) begin
      err_count++;
      $display("[ERR] pending words expected 0 seen %0d", notes.size());
      notes.delete();
    end
  endtask

  // Stalls right after a word so the number of captures during the stall is known.
  task automatic hold_words(int cycles, int n);
    int t;
    t = 0;
    @(posedge clk);
    #1;
    while (wordStrobe !== 1'b1 && t < 3000) begin
      @(posedge clk);
      #1;
      t++;
    end
    if (t >= 3000) begin
      err_count++;
      $display("[ERR] wordStrobe expected 1 seen timeout");
    end
    holdReq = 1'b1;
    repeat (cycles) @(posedge clk);
    repeat (n) notes.push_back('{1, 16'h0000});
    #1 holdReq = 1'b0;
    drain;
  endtask

  initial begin
    note_type n;
    forever begin
      @(posedge clk);
      #2;
      if (wordStrobe === 1'b1) begin
        if (notes.size() != 0) begin
          n = notes.pop_front();
          if (n.mode == 1) check("rising word", 16'h0001, {15'h0000, resultWord >= prevWord});
          else check("resultWord", n.val, resultWord);
          if (n.mode == 2) check("overRange", 16'h0001, {15'h0000, overRange});
          if (n.mode == 1) check("overRange", 16'h0000, {15'h0000, overRange});
        end
        prevWord = resultWord;
      end
    end
  end

  initial begin
    #1000000;
    err_count++;
    $display("[ERR] watchdog expected finish seen timeout");
    test_done;
  end

  initial begin
    rst = 1'b1;
    modBit = 1'b1;
    polarity_select = 1'b1;
    holdReq = 1'b0;
    chanReq = 1'b0;
    // A zero filter state codes just below midscale, since the transition sits half an LSB up.
    prevWord = 16'h7fff;
    err_count = 0;
    n_compared = 0;
    void'($urandom(32'hec04));
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    check("resultWord", 16'h8000, resultWord);
    check("settled", 16'h0000, {15'h0000, settled});
    $display("test reset done");
    repeat (8) notes.push_back('{1, 16'h0000});
    drain;
    $display("test bipolar rise done");
    hold_words(11 * 1024 + 300, 9);
    $display("test buffer fill done");
    hold_words(2100 + int'($urandom % 800), 2);
    $display("test short stall done");
    check("accepted", 16'h0001, {15'h0000, acceptCount > 0});
    @(posedge clk);
    #1 chanReq = 1'b1;
    @(posedge clk);
    #1 chanReq = 1'b0;
    repeat (2) @(posedge clk);
    #1 check("settled", 16'h0000, {15'h0000, settled});
    repeat (SC + 8) @(posedge clk);
    #1 check("settled", 16'h0001, {15'h0000, settled});
    $display("test channel change done");
    rst = 1'b1;
    polarity_select = 1'b0;
    modBit = 1'b0;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    prevWord = 16'h8000;
    repeat (2) notes.push_back('{0, 16'h0000});
    notes.push_back('{2, 16'h0000});
    drain;
    $display("test unipolar clamp done");
    test_done;
  end
endmodule // tb_sigma_delta_output_filter
